// file: hw/ft_parity.sv
// core fault tolerance unit: cache, translation and branch target parity
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
module ft_parity #(
   parameter bit FAULT_TOLERANT = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register bus
   input wire logic [ft_parity_pkg::AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ft_parity_pkg::AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // instruction cache
   input wire logic ic_wr,
   input wire logic [ft_parity_pkg::TAG_W-1:0] ic_wr_tag,
   input wire logic [31:0] ic_wr_data,
   output logic ic_wr_tag_par,
   output logic ic_wr_data_par,
   input wire logic ic_hit,
   input wire logic [ft_parity_pkg::LINE_W-1:0] ic_rd_line,
   input wire logic [ft_parity_pkg::TAG_W-1:0] ic_rd_tag,
   input wire logic ic_rd_tag_par,
   input wire logic [31:0] ic_rd_data,
   input wire logic ic_rd_data_par,
   output logic ic_inval,
   output logic [ft_parity_pkg::LINE_W-1:0] ic_inval_line,
   // data cache
   input wire logic dc_wr,
   input wire logic [ft_parity_pkg::TAG_W-1:0] dc_wr_tag,
   input wire logic [32*ft_parity_pkg::DC_WORDS-1:0] dc_wr_data,
   output logic dc_wr_tag_par,
   output logic [ft_parity_pkg::DC_WORDS-1:0] dc_wr_word_par,
   input wire logic dc_hit,
   input wire logic [ft_parity_pkg::LINE_W-1:0] dc_rd_line,
   input wire logic [ft_parity_pkg::TAG_W-1:0] dc_rd_tag,
   input wire logic dc_rd_tag_par,
   input wire logic [32*ft_parity_pkg::DC_WORDS-1:0] dc_rd_data,
   input wire logic [ft_parity_pkg::DC_WORDS-1:0] dc_rd_word_par,
   output logic dc_inval,
   output logic [ft_parity_pkg::LINE_W-1:0] dc_inval_line,
   output logic dc_write_back,
   // translation lookup
   input wire logic xl_req,
   input wire logic [ft_parity_pkg::XL_IDX_W-1:0] xl_index,
   output logic xl_done,
   output logic xl_miss,
   output logic [31:0] xl_out_hi,
   output logic [31:0] xl_out_lo,
   // branch target cache
   input wire logic bt_wr,
   input wire logic [ft_parity_pkg::BT_IDX_W-1:0] bt_wr_index,
   input wire logic [31:0] bt_wr_addr,
   input wire logic bt_lookup,
   input wire logic [ft_parity_pkg::BT_IDX_W-1:0] bt_index,
   output logic bt_hit,
   output logic [31:0] bt_target,
   input wire logic immediate_branch_op,
   input wire logic imm_branch_sync,
   input wire logic [15:0] imm_branch_offset,
   // local memory errors and exceptions
   input wire logic exception_enable_bit,
   input wire logic in_exception,
   input wire logic ibus_ue,
   input wire logic dbus_ue,
   output logic ibus_exc,
   output logic dbus_exc,
   output logic fatal_error_out
);
   ft_parity_pkg::ft_state_t s;
   ft_parity_pkg::ft_state_t n;
   logic [ft_parity_pkg::ST_W-1:0] st_set;
   logic [ft_parity_pkg::ST_W-1:0] st_clr;
   logic [31:0] wv;
   logic [32:0] view;
   logic ic_bad;
   logic dc_bad;
   logic xl_bad;
   logic bt_bad;
   logic bt_flush;
   logic exc_busy;
   ft_parity_pkg::xl_entry_t xe;
   ft_parity_pkg::bt_entry_t be;

   // =========================================================
   // register read view
   function automatic logic [32:0] rd_mux(
      input logic [ft_parity_pkg::AW-1:0] a,
      input ft_parity_pkg::ft_state_t st
   );
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      case (a)
         ft_parity_pkg::CTRL_ADDR:
         begin
            r[ft_parity_pkg::CTRL_WB_BIT] = st.wb_req;
            r[ft_parity_pkg::CTRL_WB_EFF_BIT] = st.dc_wb;
         end
         ft_parity_pkg::STATUS_ADDR:
            r[ft_parity_pkg::ST_W-1:0] = st.status;
         ft_parity_pkg::XL_INDEX_ADDR:
            r[ft_parity_pkg::XL_IDX_W-1:0] = st.xl_index;
         ft_parity_pkg::XL_HIGH_ADDR: r[31:0] = st.xl_hi;
         ft_parity_pkg::XL_LOW_ADDR: r[31:0] = st.xl_lo;
         ft_parity_pkg::XL_CMD_ADDR: r[31:0] = 32'h0000_0000;
         default: r = 33'h0_0000_0000;
      endcase
      return r;
   endfunction

   // =========================================================
   // next state
   always_comb
   begin
      n = s;
      st_set = '0;
      st_clr = '0;
      wv = 32'h0000_0000;
      view = 33'h0_0000_0000;
      xe = s.xl_mem[xl_index];
      be = s.bt_mem[bt_index];
      n.ic_inval = 1'b0;
      n.dc_inval = 1'b0;
      n.xl_done = 1'b0;
      n.bt_hit = 1'b0;
      n.ibus_exc = 1'b0;
      n.dbus_exc = 1'b0;

      // instruction cache: parity on write, check on hit
      if (ic_wr)
      begin
         n.ic_tag_par = ^ic_wr_tag;
         n.ic_data_par = ^ic_wr_data;
      end
      ic_bad = (^ic_rd_tag != ic_rd_tag_par) ||
         (^ic_rd_data != ic_rd_data_par);
      if (ic_hit && ic_bad)
      begin
         n.ic_inval = 1'b1;
         n.ic_inval_line = ic_rd_line;
         st_set[ft_parity_pkg::ST_IC] = 1'b1;
      end
      // data cache: one parity bit per word
      if (dc_wr)
      begin
         n.dc_tag_par = ^dc_wr_tag;
         for (int i = 0; i < ft_parity_pkg::DC_WORDS; i++)
            n.dc_word_par[i] = ^dc_wr_data[32*i +: 32];
      end
      dc_bad = (^dc_rd_tag != dc_rd_tag_par);
      for (int i = 0; i < ft_parity_pkg::DC_WORDS; i++)
         if (^dc_rd_data[32*i +: 32] != dc_rd_word_par[i])
            dc_bad = 1'b1;
      if (dc_hit && dc_bad)
      begin
         n.dc_inval = 1'b1;
         n.dc_inval_line = dc_rd_line;
         st_set[ft_parity_pkg::ST_DC] = 1'b1;
      end
      // translation lookup: bad parity looks like a miss
      xl_bad = (^{xe.hi, xe.lo} != xe.par);
      if (xl_req)
      begin
         n.xl_done = 1'b1;
         n.xl_out_hi = xe.hi;
         n.xl_out_lo = xe.lo;
         n.xl_miss = xl_bad || !xe.hi[ft_parity_pkg::XL_VALID_POS];
         st_set[ft_parity_pkg::ST_XL] = xl_bad;
      end
      // branch target cache
      bt_bad = (^be.addr != be.par);
      if (bt_lookup)
      begin
         n.bt_hit = be.valid && !bt_bad;
         n.bt_target = be.addr;
         st_set[ft_parity_pkg::ST_BT] = be.valid && bt_bad;
      end
      if (bt_wr)
      begin
         n.bt_mem[bt_wr_index].addr = bt_wr_addr;
         n.bt_mem[bt_wr_index].par = ^bt_wr_addr;
         n.bt_mem[bt_wr_index].valid = 1'b1;
      end
      // flush after the store so a same-cycle store is also dropped
      bt_flush = immediate_branch_op && imm_branch_sync &&
         (imm_branch_offset == ft_parity_pkg::BT_FLUSH_OFFSET);
      if (bt_flush)
         for (int i = 0; i < ft_parity_pkg::BT_ENTRIES; i++)
            n.bt_mem[i].valid = 1'b0;
      // an exception just raised counts as in progress: no one-cycle hole
      exc_busy = in_exception || s.ibus_exc || s.dbus_exc;
      if (exception_enable_bit && !s.fatal && (ibus_ue || dbus_ue))
      begin
         if (exc_busy)
         begin
            n.fatal = 1'b1;
            st_set[ft_parity_pkg::ST_FATAL] = 1'b1;
         end
         else
         begin
            n.ibus_exc = ibus_ue;
            n.dbus_exc = dbus_ue && !ibus_ue;
            st_set[ft_parity_pkg::ST_IBUS] = ibus_ue;
            st_set[ft_parity_pkg::ST_DBUS] = dbus_ue && !ibus_ue;
         end
      end
      // register bus write side
      if (s_axi_awvalid && s.awready)
      begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready)
      begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = ft_parity_pkg::RESP_OKAY;
         view = rd_mux(s.awaddr, s);
         wv = view[31:0];
         for (int b = 0; b < 4; b++)
            if (s.wstrb[b])
               wv[8*b +: 8] = s.wdata[8*b +: 8];
         case (s.awaddr)
            ft_parity_pkg::CTRL_ADDR:
               n.wb_req = wv[ft_parity_pkg::CTRL_WB_BIT];
            ft_parity_pkg::STATUS_ADDR:
               st_clr = s.wstrb[0] ? s.wdata[ft_parity_pkg::ST_W-1:0] : '0;
            ft_parity_pkg::XL_INDEX_ADDR:
               n.xl_index = wv[ft_parity_pkg::XL_IDX_W-1:0];
            ft_parity_pkg::XL_LOW_ADDR:
               n.xl_lo = wv;
            ft_parity_pkg::XL_HIGH_ADDR:
            begin
               // commits high word with the staged low word
               n.xl_hi = wv;
               n.xl_mem[s.xl_index].hi = wv;
               n.xl_mem[s.xl_index].lo = s.xl_lo;
               n.xl_mem[s.xl_index].par = ^{wv, s.xl_lo};
            end
            ft_parity_pkg::XL_CMD_ADDR:
               if (wv[ft_parity_pkg::XL_CMD_READ_BIT])
               begin
                  n.xl_hi = s.xl_mem[s.xl_index].hi;
                  n.xl_lo = s.xl_mem[s.xl_index].lo;
                  if (^{s.xl_mem[s.xl_index].hi, s.xl_mem[s.xl_index].lo}
                     != s.xl_mem[s.xl_index].par)
                  begin
                     n.xl_hi[ft_parity_pkg::XL_VALID_POS] = 1'b0;
                     n.xl_mem[s.xl_index].hi[ft_parity_pkg::XL_VALID_POS] =
                        1'b0;
                     st_set[ft_parity_pkg::ST_XL] = 1'b1;
                  end
               end
            default: n.bresp = ft_parity_pkg::RESP_SLVERR;
         endcase
      end
      // register bus read side
      if (s_axi_arvalid && s.arready)
      begin
         view = rd_mux(s_axi_araddr, s);
         n.rvalid = 1'b1;
         n.rdata = view[31:0];
         n.rresp = view[32] ? ft_parity_pkg::RESP_OKAY
            : ft_parity_pkg::RESP_SLVERR;
      end
      else if (s.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;
      n.arready = !n.rvalid;
      // sticky status: set beats clear; fatal only leaves through reset
      st_clr[ft_parity_pkg::ST_FATAL] = 1'b0;
      n.status = (s.status & ~st_clr) | st_set;
      n.dc_wb = n.wb_req && !FAULT_TOLERANT;
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         s <= '0;
      else
         s <= n;
   end

   // =========================================================
   // outputs
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign ic_wr_tag_par = s.ic_tag_par;
   assign ic_wr_data_par = s.ic_data_par;
   assign ic_inval = s.ic_inval;
   assign ic_inval_line = s.ic_inval_line;
   assign dc_wr_tag_par = s.dc_tag_par;
   assign dc_wr_word_par = s.dc_word_par;
   assign dc_inval = s.dc_inval;
   assign dc_inval_line = s.dc_inval_line;
   assign dc_write_back = s.dc_wb;
   assign xl_done = s.xl_done;
   assign xl_miss = s.xl_miss;
   assign xl_out_hi = s.xl_out_hi;
   assign xl_out_lo = s.xl_out_lo;
   assign bt_hit = s.bt_hit;
   assign bt_target = s.bt_target;
   assign ibus_exc = s.ibus_exc;
   assign dbus_exc = s.dbus_exc;
   assign fatal_error_out = s.fatal;

   // =========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_ic_hit_inval: assert property ((ic_hit && ic_bad) |=>
      (ic_inval && ic_inval_line == $past(ic_rd_line)))
      else $error("icache parity error did not invalidate the line");
   a_ic_clean_hit: assert property (!(ic_hit && ic_bad) |=> !ic_inval)
      else $error("icache invalidated without a parity error");
   a_dc_write_thru: assert property (FAULT_TOLERANT |-> !dc_write_back)
      else $error("write-back enabled under fault tolerance");
   a_ic_wr_par: assert property (ic_wr |=>
      (ic_wr_tag_par == ^$past(ic_wr_tag) &&
       ic_wr_data_par == ^$past(ic_wr_data)))
      else $error("icache write parity wrong");
   a_xl_bad_miss: assert property ((xl_req && xl_bad) |=>
      (xl_done && xl_miss))
      else $error("translation parity error not reported as miss");
   a_bt_bad_drop: assert property ((bt_lookup && bt_bad) |=> !bt_hit)
      else $error("bad branch target used");
   a_bt_flush_all: assert property ((bt_flush ##1 bt_lookup) |=>
      !bt_hit)
      else $error("branch target cache not cleared");
   a_bus_exc_ent: assert property ((exception_enable_bit && ibus_ue &&
      !exc_busy && !fatal_error_out) |=> (ibus_exc && !dbus_exc))
      else $error("instruction bus exception missing");
   a_fatal_set: assert property ((exception_enable_bit &&
      (ibus_ue || dbus_ue) && exc_busy) |=> fatal_error_out)
      else $error("double fault did not halt");
   a_fatal_hold: assert property (fatal_error_out |=>
      (fatal_error_out && !ibus_exc && !dbus_exc))
      else $error("fatal state left or exception raised after halt");
endmodule

// file: pkg/ft_parity_pkg.sv
// constants and carrier types for the core fault tolerance parity unit
// Function
// - check cache parity on every instruction or data cache hit
// - on cache parity error invalidate the line so it is refetched
// - with fault tolerance the data cache is write-through only
// - on cache write store parity: tag, icache data, each dcache word
// - translation parity error during lookup raises a translation miss
// - writing a translation entry via high/low registers stores one parity bit
// - reading an entry checks parity; on error its valid bit is cleared
// - branch target with bad parity is dropped; branch runs normally
// - storing a branch target stores one parity bit with it
// - with exception enable, local memory error raises ibus or dbus exception
// - bus exception during exception handling halts and sets fatal output
// - writing high entry register with valid clear invalidates that entry
// - synchronizing immediate branch with offset 4 clears branch target cache
package ft_parity_pkg;
   // =========================================================
   // sizes
   localparam int AW = 8;
   localparam int TAG_W = 20;
   localparam int LINE_W = 8;
   localparam int DC_WORDS = 4;
   localparam int XL_ENTRIES = 8;
   localparam int XL_IDX_W = 3;
   localparam int XL_VALID_POS = 6;
   localparam int BT_ENTRIES = 8;
   localparam int BT_IDX_W = 3;
   localparam logic [15:0] BT_FLUSH_OFFSET = 16'h0004;
   // =========================================================
   // register map (byte addresses)
   localparam logic [AW-1:0] CTRL_ADDR = 8'h00;
   localparam logic [AW-1:0] STATUS_ADDR = 8'h04;
   localparam logic [AW-1:0] XL_INDEX_ADDR = 8'h08;
   localparam logic [AW-1:0] XL_HIGH_ADDR = 8'h0C;
   localparam logic [AW-1:0] XL_LOW_ADDR = 8'h10;
   localparam logic [AW-1:0] XL_CMD_ADDR = 8'h14;
   localparam int CTRL_WB_BIT = 0;
   localparam int CTRL_WB_EFF_BIT = 1;
   localparam int XL_CMD_READ_BIT = 0;
   // status bits
   localparam int ST_IC = 0;
   localparam int ST_DC = 1;
   localparam int ST_XL = 2;
   localparam int ST_BT = 3;
   localparam int ST_IBUS = 4;
   localparam int ST_DBUS = 5;
   localparam int ST_FATAL = 6;
   localparam int ST_W = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =========================================================
   // carriers
   typedef struct packed {
      logic [31:0] hi;
      logic [31:0] lo;
      logic par;
   } xl_entry_t;
   typedef struct packed {
      logic valid;
      logic par;
      logic [31:0] addr;
   } bt_entry_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic rvalid;
      logic aw_got;
      logic w_got;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [31:0] rdata;
      logic wb_req;
      logic [ST_W-1:0] status;
      logic [XL_IDX_W-1:0] xl_index;
      logic [31:0] xl_hi;
      logic [31:0] xl_lo;
      xl_entry_t [XL_ENTRIES-1:0] xl_mem;
      bt_entry_t [BT_ENTRIES-1:0] bt_mem;
      logic ic_tag_par;
      logic ic_data_par;
      logic ic_inval;
      logic [LINE_W-1:0] ic_inval_line;
      logic dc_tag_par;
      logic [DC_WORDS-1:0] dc_word_par;
      logic dc_inval;
      logic [LINE_W-1:0] dc_inval_line;
      logic dc_wb;
      logic xl_done;
      logic xl_miss;
      logic [31:0] xl_out_hi;
      logic [31:0] xl_out_lo;
      logic bt_hit;
      logic [31:0] bt_target;
      logic ibus_exc;
      logic dbus_exc;
      logic fatal;
   } ft_state_t;
endpackage

// file: verification/ecc_mem_model.sv
// local memory partner: corrects single flips, flags double flips
module ecc_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // read request with the number of flipped bits it meets
   input wire logic mem_rd,
   input wire logic mem_dbus,
   input wire logic [1:0] mem_flips,
   // uncorrectable error flags towards the core
   output logic ibus_ue,
   output logic dbus_ue
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // error signalling
   // minimal build: no software registers, so no correctable error
   // interrupt and no failing address is ever exposed
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ibus_ue <= 1'b0;
         dbus_ue <= 1'b0;
      end
      else
      begin
         // one flip is repaired silently, two are flagged
         ibus_ue <= mem_rd && !mem_dbus && mem_flips > 2'h1;
         dbus_ue <= mem_rd && mem_dbus && mem_flips > 2'h1;
      end
   end
endmodule

// file: verification/cpu_fault_tolerance_parity_bench.sv
// self-checking bench for the fault tolerance parity unit
module cpu_fault_tolerance_parity_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ic_wr = 1'b0, ic_hit = 1'b0, ic_rd_tag_par = 1'b0;
   logic ic_rd_data_par = 1'b0, ic_wr_tag_par, ic_wr_data_par, ic_inval;
   logic [19:0] ic_wr_tag = '0, ic_rd_tag = '0;
   logic [19:0] dc_wr_tag = '0, dc_rd_tag = '0;
   logic [31:0] ic_wr_data = '0, ic_rd_data = '0, bt_wr_addr = '0;
   logic [31:0] bt_target, xl_out_hi, xl_out_lo, hi, lo;
   logic [7:0] ic_rd_line = '0, dc_rd_line = '0;
   logic [7:0] ic_inval_line, dc_inval_line;
   logic dc_wr = 1'b0, dc_hit = 1'b0, dc_rd_tag_par = 1'b0, dc_inval;
   logic dc_wr_tag_par, dc_write_back;
   logic [127:0] dc_wr_data = '0, dc_rd_data = '0, dw;
   logic [3:0] dc_rd_word_par = '0, dc_wr_word_par;
   logic xl_req = 1'b0, xl_done, xl_miss, bt_wr = 1'b0, bt_lookup = 1'b0;
   logic [2:0] xl_index = '0, bt_wr_index = '0, bt_index = '0;
   logic bt_hit, immediate_branch_op = 1'b0, imm_branch_sync = 1'b0;
   logic [15:0] imm_branch_offset = '0;
   logic exception_enable_bit = 1'b0, in_exception = 1'b0;
   logic ibus_ue, dbus_ue, ibus_exc, dbus_exc, fatal_error_out;
   logic mem_rd = 1'b0, mem_dbus = 1'b0;
   logic [1:0] mem_flips = '0;
   logic [31:0] seed = 32'h9B2998AF;
   int checked = 0;
   int fails = 0;

   always #5 clk = ~clk;

   ft_parity #(.FAULT_TOLERANT(1'b1)) i_ft_parity (.*);
   ecc_mem_model i_ecc_mem_model (.*);

   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   function automatic logic [3:0] wpar(input logic [127:0] d);
      for (int k = 0; k < 4; k++)
         wpar[k] = ^d[32*k +: 32];
   endfunction

   task automatic chk(input string nm, input logic [127:0] e,
      input logic [127:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic hang();
      fails++;
      $display("CHECK FAILED bus answer expected in 40 cycles seen none");
      wrap_up();
   endtask

   // pulses last one cycle; the registered answer is read once it lands
   task automatic step();
      @(posedge clk);
      {ic_wr, ic_hit, dc_wr, dc_hit, xl_req, bt_wr, bt_lookup} <= '0;
      {immediate_branch_op, mem_rd} <= '0;
      #1;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            chk("bresp", er, s_axi_bresp);
            return;
         end
      end
      hang();
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            s_axi_rready <= 1'b0;
            chk("rdata", ed, s_axi_rdata);
            chk("rresp", er, s_axi_rresp);
            return;
         end
      end
      hang();
   endtask

   // local memory read meeting flipped bits, then the core's reaction
   task automatic ue_try(input logic en, input logic inx,
      input logic dbus, input logic [1:0] flips);
      @(posedge clk);
      exception_enable_bit <= en;
      in_exception <= inx;
      mem_rd <= 1'b1;
      mem_dbus <= dbus;
      mem_flips <= flips;
      step();
      @(posedge clk);
      #1;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      axi_rd(ft_parity_pkg::STATUS_ADDR, 32'h0, 2'h0);
      axi_rd(8'h40, 32'h0, 2'h2);
      axi_wr(8'h40, 32'hFFFF_FFFF, 2'h2);
      axi_wr(ft_parity_pkg::CTRL_ADDR, 32'h1, 2'h0);
      axi_rd(ft_parity_pkg::CTRL_ADDR, 32'h1, 2'h0);
      chk("dc_write_back", 1'b0, dc_write_back);
      $display("test registers done");
      // hits alternate good, bad tag parity, bad data parity
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         @(posedge clk);
         ic_wr <= 1'b1;
         ic_wr_tag <= seed[19:0];
         ic_wr_data <= ~seed;
         step();
         chk("ic_wr_tag_par", ^seed[19:0], ic_wr_tag_par);
         chk("ic_wr_data_par", ^(~seed), ic_wr_data_par);
         @(posedge clk);
         ic_hit <= 1'b1;
         ic_rd_line <= seed[31:24];
         ic_rd_tag <= seed[19:0];
         ic_rd_data <= ~seed;
         ic_rd_tag_par <= ^seed[19:0] ^ (i % 3 == 1);
         ic_rd_data_par <= ^(~seed) ^ (i % 3 == 2);
         step();
         chk("ic_inval", i % 3 != 0, ic_inval);
         if (i % 3 != 0)
            chk("ic_inval_line", seed[31:24], ic_inval_line);
      end
      $display("test icache done");
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         dw = {seed, ~seed, seed ^ 32'h1234_5678, seed + 32'h1};
         @(posedge clk);
         dc_wr <= 1'b1;
         dc_wr_tag <= seed[27:8];
         dc_wr_data <= dw;
         step();
         chk("dc_wr_tag_par", ^seed[27:8], dc_wr_tag_par);
         chk("dc_wr_word_par", wpar(dw), dc_wr_word_par);
         @(posedge clk);
         dc_hit <= 1'b1;
         dc_rd_line <= seed[7:0];
         dc_rd_tag <= seed[27:8];
         dc_rd_data <= dw;
         dc_rd_tag_par <= ^seed[27:8];
         dc_rd_word_par <= wpar(dw) ^ (i[0] ? 4'h1 << i[2:1] : 4'h0);
         step();
         chk("dc_inval", i[0], dc_inval);
         if (i[0])
            chk("dc_inval_line", seed[7:0], dc_inval_line);
      end
      axi_rd(ft_parity_pkg::STATUS_ADDR, 32'h3, 2'h0);
      axi_wr(ft_parity_pkg::STATUS_ADDR, 32'h3, 2'h0);
      axi_rd(ft_parity_pkg::STATUS_ADDR, 32'h0, 2'h0);
      $display("test dcache done");
      // every fourth entry is written with its valid bit cleared
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         hi = seed;
         hi[6] = i % 4 != 3;
         lo = ~seed;
         axi_wr(ft_parity_pkg::XL_INDEX_ADDR, i, 2'h0);
         axi_wr(ft_parity_pkg::XL_LOW_ADDR, lo, 2'h0);
         axi_wr(ft_parity_pkg::XL_HIGH_ADDR, hi, 2'h0);
         @(posedge clk);
         xl_req <= 1'b1;
         xl_index <= i[2:0];
         step();
         chk("xl_done", 1'b1, xl_done);
         chk("xl_miss", !hi[6], xl_miss);
         chk("xl_out_hi", hi, xl_out_hi);
         chk("xl_out_lo", lo, xl_out_lo);
         axi_wr(ft_parity_pkg::XL_CMD_ADDR, 32'h1, 2'h0);
         axi_rd(ft_parity_pkg::XL_HIGH_ADDR, hi, 2'h0);
         axi_rd(ft_parity_pkg::XL_LOW_ADDR, lo, 2'h0);
      end
      $display("test translation done");
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         @(posedge clk);
         bt_wr <= 1'b1;
         bt_wr_index <= i[2:0];
         bt_wr_addr <= seed;
         step();
         @(posedge clk);
         bt_lookup <= 1'b1;
         bt_index <= i[2:0];
         step();
         chk("bt_hit", 1'b1, bt_hit);
         chk("bt_target", seed, bt_target);
      end
      // only the full synchronizing branch by 4 may flush
      for (int j = 0; j < 4; j++)
      begin
         @(posedge clk);
         immediate_branch_op <= j != 2;
         imm_branch_sync <= j != 1;
         imm_branch_offset <= j == 0 ? 16'h0008 : 16'h0004;
         // look up in the very next cycle, as a fetch would
         @(posedge clk);
         immediate_branch_op <= 1'b0;
         bt_lookup <= 1'b1;
         bt_index <= 3'h5;
         step();
         chk("bt_hit", j != 3, bt_hit);
      end
      $display("test branch target done");
      // disabled, corrected, ibus, dbus, then nested fault
      for (int t = 0; t < 5; t++)
      begin
         ue_try(t > 0, t == 4, t > 2, t == 1 ? 2'h1 : 2'h2);
         chk("ibus_exc", t == 2, ibus_exc);
         chk("dbus_exc", t == 3, dbus_exc);
         chk("fatal_error_out", t == 4, fatal_error_out);
      end
      axi_rd(ft_parity_pkg::STATUS_ADDR, 32'h70, 2'h0);
      axi_wr(ft_parity_pkg::STATUS_ADDR, 32'h7F, 2'h0);
      axi_rd(ft_parity_pkg::STATUS_ADDR, 32'h40, 2'h0);
      chk("fatal_error_out", 1'b1, fatal_error_out);
      $display("test exceptions done");
      wrap_up();
   end
endmodule
